// *** scp_defines.vh ***
// constants shared by the serial command parser and its testbench
// assumes a 250 MHz controller clock and an external uart doing bit framing
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// ------------------------------------------------------------------
// link timing
// ------------------------------------------------------------------
`define SCP_CLK_HZ         250000000
`define SCP_BAUD           115200
`define SCP_CHAR_BITS      10
// least character time, rounded up to whole cycles
`define SCP_CHAR_CYC       ((64'd0 + `SCP_CLK_HZ * `SCP_CHAR_BITS + `SCP_BAUD - 1) / `SCP_BAUD)
// history write-back interval in seconds (2.5 hours)
`define SCP_HIST_PERIOD_S  9000
`define SCP_HIST_CYC       (42'd9000 * 42'd250000000)

// ------------------------------------------------------------------
// characters
// ------------------------------------------------------------------
`define SCP_CH_CR    8'h0d
`define SCP_CH_LF    8'h0a
`define SCP_CH_SP    8'h20
`define SCP_CH_ERR   8'h3f
`define SCP_C_HELP   8'h3f
`define SCP_C_DACTAB 8'h52
`define SCP_C_TMRTAB 8'h50
`define SCP_C_VER    8'h58
`define SCP_C_NEVT   8'h6e
`define SCP_C_DUMP   8'h64
`define SCP_C_FLT    8'h78
`define SCP_C_FIRST  8'h79
`define SCP_C_FLASH  8'h51
`define SCP_C_LOGGO  8'h53
`define SCP_C_LOGSTP 8'h73
`define SCP_C_RESET  8'h72
`define SCP_C_ODOT   8'h5a
`define SCP_C_ODOA   8'h7a
`define SCP_C_YES    8'h59
`define SCP_C_FACT   8'h46
`define SCP_HELP_TEXT "?RPXvtcwgndxyVTCWGQSsrZzF"

// ------------------------------------------------------------------
// parameter classes (upper bits of the mirror address)
// ------------------------------------------------------------------
`define SCP_CLS_DAC  3'h0
`define SCP_CLS_TMR  3'h1
`define SCP_CLS_DIO  3'h2
`define SCP_CLS_PWR  3'h3
`define SCP_CLS_PG   3'h4

// dump record: 3 index + space + 12 pattern + space + 8 timestamp
`define SCP_DUMP_LEN 5'd25
`define SCP_DUMP_SP1 5'd3
`define SCP_DUMP_SP2 5'd16
`define SCP_DUMP_MAX 7'd64
`endif

// *** scp_fifo.v ***
// synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module scp_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         CLK,
  input  wire         SRST,
  input  wire [W-1:0] IN_DATA,
  input  wire         IN_VALID,
  output wire         IN_READY,
  output wire [W-1:0] OUT_DATA,
  output wire         OUT_VALID,
  input  wire         OUT_READY
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr;
  reg [AW-1:0] rd;
  reg [AW:0]   cnt;
  wire         push = IN_VALID & IN_READY;
  wire         pop  = OUT_VALID & OUT_READY;

  assign IN_READY  = (cnt != DEPTH[AW:0]);
  assign OUT_VALID = (cnt != {(AW+1){1'b0}});
  assign OUT_DATA  = mem[rd];

  always @(posedge CLK) begin
    if (SRST) begin
      wr  <= {AW{1'b0}};
      rd  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr] <= IN_DATA;
        wr      <= (wr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr + 1'b1;
      end
      if (pop)
        rd <= (rd == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd + 1'b1;
      if (push & ~pop)
        cnt <= cnt + 1'b1;
      else if (pop & ~push)
        cnt <= cnt - 1'b1;
    end
  end
endmodule // scp_fifo

// *** scp_parser.v ***
// serial command interpreter: line assembly, decode, replies, flash and log control
// assumes a uart outside that delivers and takes bytes; mirror, logger, fault
// latches and odometers live outside and follow the strobes issued here
// Function
// R1 - link runs 115200 baud, 8 data bits, no parity, both ends
// R2 - data requests answered with the bare number only
// R3 - replies keep leading zeros; entries must carry every digit
// R4 - printable ascii only, every command and reply ends cr lf
// R5 - load parameter and history mirrors from flash before serving
// R6 - serial parameter writes touch only the mirror until copy command
// R7 - panel changes go to flash on return to top display
// R8 - commands accepted while enabled, no lockout
// R9 - pulse generator changes apply only at next counter reload
// R10 - '?', 'R', 'P', 'X' give help, dac, timer, version info
// R11 - lower-case v t c w g n read back a value
// R12 - 'd' dumps up to 64 events of 25 characters each
// R13 - 'x' returns all fault bits as 8 hex characters
// R14 - 'y' returns first-latched fault bits as 8 hex characters
// R15 - upper-case letter plus indices plus three hex digits sets value
// R16 - history to flash on enabled drop, else every 2.5 hours
// R17 - 'Q' forces flash write of parameters and history
// R18 - 'S' clears log and starts logging bit changes with timestamp
// R19 - 's' stops logger; logger must be stopped before dumping
// R20 - 'r' clears fault latches as panel reset; live faults stay
// R21 - 'Z' then 'Y' clears tube odometers, then flash write
// R22 - 'z' then 'Y' clears antenna odometer, then flash write
// R23 - 'F' restores factory parameter values
// R24 - anything but 'Y' after odometer reset cancels it
`timescale 1ns/100ps
`include "scp_defines.vh"
module scp_parser #(
  parameter CHAR_CYC  = `SCP_CHAR_CYC,
  parameter [41:0] HIST_CYC = `SCP_HIST_CYC,
  parameter [15:0] FW_VERSION = 16'h0001,
  parameter [31:0] BUILD_DATE = 32'h00000000,
  parameter [7:0]  DAC_COUNT  = 8'h20,
  parameter [7:0]  TMR_COUNT  = 8'h0b,
  parameter        FIFO_DEPTH = 16,
  parameter        FIFO_AW    = 4
) (
  input  wire        CLK,
  input  wire        SRST,
  input  wire [7:0]  RX_DATA,
  input  wire        RX_VALID,
  output reg         RX_READY,
  output reg  [7:0]  TX_DATA,
  output reg         TX_VALID,
  input  wire        TX_READY,
  output reg         READY,
  output reg         FLASH_LOAD,
  input  wire        FLASH_DONE,
  output reg         FLASH_PARAM_WR,
  output reg         FLASH_HIST_WR,
  input  wire        PANEL_TOP,
  input  wire        ENABLED,
  output reg         PG_RELOAD,
  output reg         PARAM_WE,
  output reg         PARAM_RE,
  output reg  [10:0] PARAM_ADDR,
  output reg  [11:0] PARAM_WDATA,
  input  wire [11:0] PARAM_RDATA,
  output reg         FACTORY_LOAD,
  output reg         LOG_START,
  output reg         LOG_STOP,
  input  wire [6:0]  LOG_COUNT,
  output reg  [5:0]  LOG_RADDR,
  input  wire [79:0] LOG_RDATA,
  input  wire [31:0] FAULT_BITS,
  input  wire [31:0] FIRST_FAULT,
  output reg         FAULT_RESET,
  output reg         ODO_TUBE_CLR,
  output reg         ODO_ANT_CLR
);
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam [8:0] S_LOAD = 9'h001, S_BOOT = 9'h002, S_RX  = 9'h004,
                   S_EXEC = 9'h008, S_RDW  = 9'h010, S_EMIT = 9'h020,
                   S_CR   = 9'h040, S_LF   = 9'h080, S_DRD = 9'h100;

  reg  [8:0]   state;
  reg  [7:0]   lbuf [0:7];
  reg  [3:0]   len;
  reg          lerr;
  reg  [1:0]   confirm;
  reg          log_run;
  reg  [199:0] em_val;
  reg  [4:0]   em_n;
  reg  [4:0]   em_pos;
  reg          em_txt;
  reg          dmode;
  reg  [5:0]   didx;
  reg  [6:0]   dleft;
  reg          en_prev;
  reg  [41:0]  hist_cnt;
  reg  [15:0]  pace;

  // ------------------------------------------------------------------
  // hex helpers
  // ------------------------------------------------------------------
  function [4:0] hexv;
    input [7:0] ch;
    begin
      if (ch >= 8'h30 && ch <= 8'h39)
        hexv = {1'b0, ch[3:0]};
      else if ((ch | 8'h20) >= 8'h61 && (ch | 8'h20) <= 8'h66)
        hexv = {1'b0, ch[3:0] + 4'h9};
      else
        hexv = 5'h10;
    end
  endfunction

  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'ha) ? {4'h3, n} : {4'h4, 4'h0} + {4'h0, n - 4'h9};
    end
  endfunction

  // per-character hex decode of the line
  wire [3:0] dv [0:7];
  wire [7:0] dbad;
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_hex
      wire [4:0] h = hexv(lbuf[k]);
      assign dv[k]   = h[3:0];
      assign dbad[k] = h[4] & (k != 0) & (k < len);
    end
  endgenerate

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  wire [7:0] cmd   = lbuf[0];
  wire [7:0] lc    = cmd | 8'h20;
  wire       upper = (cmd >= 8'h41) && (cmd <= 8'h5a);
  reg  [2:0] cls;
  reg        isprm;
  reg        two;
  always @* begin
    cls   = `SCP_CLS_DAC;
    isprm = 1'b1;
    two   = 1'b1;
    case (lc)
      8'h76:   cls = `SCP_CLS_DAC;
      8'h74:   cls = `SCP_CLS_TMR;
      8'h67:   cls = `SCP_CLS_PG;
      8'h63: begin
        cls = `SCP_CLS_DIO;
        two = 1'b0;
      end
      8'h77: begin
        cls = `SCP_CLS_PWR;
        two = 1'b0;
      end
      default: isprm = 1'b0;
    endcase
  end
  // R15 digit count check
  wire [3:0]  exp_len = 4'd1 + (two ? 4'd2 : 4'd1) + (upper ? 4'd3 : 4'd0);
  wire        bad_prm = lerr | (len != exp_len) | (|dbad);
  wire        bad_one = lerr | (len != 4'd1);
  wire [10:0] p_addr  = two ? {cls, dv[1], dv[2]} : {cls, 4'h0, dv[1]};
  wire [11:0] p_data  = two ? {dv[3], dv[4], dv[5]} : {dv[2], dv[3], dv[4]};

  // ------------------------------------------------------------------
  // reply character and fifo path
  // ------------------------------------------------------------------
  wire       is_sp   = dmode && (em_pos == `SCP_DUMP_SP1 || em_pos == `SCP_DUMP_SP2);
  wire [7:0] em_char = is_sp ? `SCP_CH_SP : em_txt ? em_val[199:192] : hexc(em_val[199:196]);
  wire       f_ivalid = |(state & (S_EMIT | S_CR | S_LF));
  // R4 every reply ends cr lf
  wire [7:0] f_idata  = state[6] ? `SCP_CH_CR : state[7] ? `SCP_CH_LF : em_char;
  wire       f_iready;
  wire [7:0] f_odata;
  wire       f_ovalid;
  // one character handed over per character time so the uart never overruns
  wire       f_oready = ~TX_VALID & (pace == 16'h0000);

  scp_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_txq (
    .CLK       (CLK),
    .SRST      (SRST),
    .IN_DATA   (f_idata),
    .IN_VALID  (f_ivalid),
    .IN_READY  (f_iready),
    .OUT_DATA  (f_odata),
    .OUT_VALID (f_ovalid),
    .OUT_READY (f_oready)
  );

  // ------------------------------------------------------------------
  // transmit stage with character pacing
  // ------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
      pace     <= 16'h0000;
    end else begin
      if (TX_VALID && TX_READY) begin
        TX_VALID <= 1'b0;
        // R1 character time at 115200 baud
        pace     <= CHAR_CYC[15:0] - 16'h0001;
      end else if (pace != 16'h0000) begin
        pace <= pace - 16'h0001;
      end
      if (f_oready && f_ovalid) begin
        TX_VALID <= 1'b1;
        TX_DATA  <= f_odata;
      end
    end
  end

  // ------------------------------------------------------------------
  // flash write-back and reload strobes
  // ------------------------------------------------------------------
  wire en_fall  = en_prev & ~ENABLED;
  wire hist_hit = (hist_cnt == HIST_CYC - 42'd1);

  // ------------------------------------------------------------------
  // main sequencer
  // ------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      state          <= S_LOAD;
      RX_READY       <= 1'b0;
      READY          <= 1'b0;
      FLASH_LOAD     <= 1'b0;
      FLASH_PARAM_WR <= 1'b0;
      FLASH_HIST_WR  <= 1'b0;
      PG_RELOAD      <= 1'b0;
      PARAM_WE       <= 1'b0;
      PARAM_RE       <= 1'b0;
      PARAM_ADDR     <= 11'h000;
      PARAM_WDATA    <= 12'h000;
      FACTORY_LOAD   <= 1'b0;
      LOG_START      <= 1'b0;
      LOG_STOP       <= 1'b0;
      LOG_RADDR      <= 6'h00;
      FAULT_RESET    <= 1'b0;
      ODO_TUBE_CLR   <= 1'b0;
      ODO_ANT_CLR    <= 1'b0;
      len            <= 4'h0;
      lerr           <= 1'b0;
      confirm        <= 2'b00;
      log_run        <= 1'b0;
      em_val         <= 200'h0;
      em_n           <= 5'h00;
      em_pos         <= 5'h00;
      em_txt         <= 1'b0;
      dmode          <= 1'b0;
      didx           <= 6'h00;
      dleft          <= 7'h00;
      en_prev        <= 1'b0;
      hist_cnt       <= 42'h0;
    end else begin
      en_prev        <= ENABLED;
      // R9 pulse generator reloads from the mirror only on enable rising
      PG_RELOAD      <= ENABLED & ~en_prev;
      // R7 panel edits reach flash on return to top display
      FLASH_PARAM_WR <= PANEL_TOP & READY;
      // R16 history on enable drop or interval expiry
      FLASH_HIST_WR  <= (en_fall | hist_hit) & READY;
      hist_cnt       <= (FLASH_HIST_WR | hist_hit) ? 42'h0 : hist_cnt + 42'd1;
      FLASH_LOAD     <= 1'b0;
      PARAM_WE       <= 1'b0;
      PARAM_RE       <= 1'b0;
      FACTORY_LOAD   <= 1'b0;
      LOG_START      <= 1'b0;
      LOG_STOP       <= 1'b0;
      FAULT_RESET    <= 1'b0;
      ODO_TUBE_CLR   <= 1'b0;
      ODO_ANT_CLR    <= 1'b0;
      case (state)
        S_LOAD: begin
          // R5 mirrors filled from flash before any command is served
          FLASH_LOAD <= 1'b1;
          state      <= S_BOOT;
        end
        S_BOOT: begin
          if (FLASH_DONE) begin
            READY    <= 1'b1;
            RX_READY <= 1'b1;
            state    <= S_RX;
          end
        end
        S_RX: begin
          // R8 no lockout while enabled
          if (RX_VALID) begin
            if (RX_DATA == `SCP_CH_CR) begin
              RX_READY <= 1'b0;
              state    <= S_EXEC;
            end else if (RX_DATA != `SCP_CH_LF) begin
              // R4 non-printable or overlong lines are rejected
              if (len == 4'h8 || RX_DATA < 8'h20 || RX_DATA > 8'h7e)
                lerr <= 1'b1;
              else begin
                lbuf[len[2:0]] <= RX_DATA;
                len            <= len + 4'h1;
              end
            end
          end
        end
        S_EXEC: begin
          em_val <= 200'h0;
          em_n   <= 5'h00;
          em_pos <= 5'h00;
          em_txt <= 1'b0;
          dmode  <= 1'b0;
          len    <= 4'h0;
          lerr   <= 1'b0;
          state  <= S_CR;
          if (confirm != 2'b00) begin
            confirm <= 2'b00;
            if (!bad_one && cmd == `SCP_C_YES) begin
              // R21 tube odometers after confirmation
              ODO_TUBE_CLR  <= confirm[0];
              // R22 antenna odometer after confirmation
              ODO_ANT_CLR   <= confirm[1];
              FLASH_HIST_WR <= 1'b1;
            end
            // R24 otherwise the pending clear is dropped
          end else if (isprm) begin
            if (bad_prm) begin
              // R3 short entries refused
              em_val[199:192] <= `SCP_CH_ERR;
              em_txt          <= 1'b1;
              em_n            <= 5'd1;
              state           <= S_EMIT;
            end else if (upper) begin
              // R6 serial writes touch only the mirror
              PARAM_WE    <= 1'b1;
              PARAM_ADDR  <= p_addr;
              PARAM_WDATA <= p_data;
            end else begin
              // R11 read from the mirror
              PARAM_RE   <= 1'b1;
              PARAM_ADDR <= p_addr;
              state      <= S_RDW;
            end
          end else if (bad_one) begin
            em_val[199:192] <= `SCP_CH_ERR;
            em_txt          <= 1'b1;
            em_n            <= 5'd1;
            state           <= S_EMIT;
          end else begin
            state <= S_EMIT;
            case (cmd)
              `SCP_C_HELP: begin
                // R10 command letter list
                em_val <= `SCP_HELP_TEXT;
                em_txt <= 1'b1;
                em_n   <= 5'd25;
              end
              `SCP_C_DACTAB: begin
                // R10 channel counts
                em_val[199:192] <= DAC_COUNT;
                em_n            <= 5'd2;
              end
              `SCP_C_TMRTAB: begin
                em_val[199:192] <= TMR_COUNT;
                em_n            <= 5'd2;
              end
              `SCP_C_VER: begin
                em_val[199:152] <= {FW_VERSION, BUILD_DATE};
                em_n            <= 5'd12;
              end
              `SCP_C_NEVT: begin
                // R2 bare value, R3 leading zeros kept
                em_val[199:192] <= {1'b0, LOG_COUNT};
                em_n            <= 5'd2;
              end
              `SCP_C_FLT: begin
                // R13 live fault bits
                em_val[199:168] <= FAULT_BITS;
                em_n            <= 5'd8;
              end
              `SCP_C_FIRST: begin
                // R14 first-latched bits
                em_val[199:168] <= FIRST_FAULT;
                em_n            <= 5'd8;
              end
              `SCP_C_DUMP: begin
                // R19 dump refused while logging
                if (log_run) begin
                  em_val[199:192] <= `SCP_CH_ERR;
                  em_txt          <= 1'b1;
                  em_n            <= 5'd1;
                end else begin
                  // R12 at most 64 records
                  didx  <= 6'h00;
                  dleft <= (LOG_COUNT > `SCP_DUMP_MAX) ? `SCP_DUMP_MAX : LOG_COUNT;
                  LOG_RADDR <= 6'h00;
                  state <= (LOG_COUNT == 7'h00) ? S_CR : S_DRD;
                end
              end
              `SCP_C_FLASH: begin
                // R17 both mirrors to flash
                FLASH_PARAM_WR <= 1'b1;
                FLASH_HIST_WR  <= 1'b1;
                state          <= S_CR;
              end
              `SCP_C_LOGGO: begin
                // R18 clear and start logger
                LOG_START <= 1'b1;
                log_run   <= 1'b1;
                state     <= S_CR;
              end
              `SCP_C_LOGSTP: begin
                // R19 stop logger
                LOG_STOP <= 1'b1;
                log_run  <= 1'b0;
                state    <= S_CR;
              end
              `SCP_C_RESET: begin
                // R20 same strobe as panel reset
                FAULT_RESET <= 1'b1;
                state       <= S_CR;
              end
              `SCP_C_ODOT: begin
                confirm <= 2'b01;
                state   <= S_CR;
              end
              `SCP_C_ODOA: begin
                confirm <= 2'b10;
                state   <= S_CR;
              end
              `SCP_C_FACT: begin
                // R23 factory defaults
                FACTORY_LOAD <= 1'b1;
                state        <= S_CR;
              end
              default: begin
                em_val[199:192] <= `SCP_CH_ERR;
                em_txt          <= 1'b1;
                em_n            <= 5'd1;
              end
            endcase
          end
        end
        S_RDW: begin
          em_val[199:188] <= PARAM_RDATA;
          em_n            <= 5'd3;
          state           <= S_EMIT;
        end
        S_DRD: begin
          // R12 index, pattern and timestamp in one record
          em_val[199:108] <= {6'h00, didx, LOG_RDATA};
          em_n            <= `SCP_DUMP_LEN;
          em_pos          <= 5'h00;
          dmode           <= 1'b1;
          didx            <= didx + 6'h01;
          dleft           <= dleft - 7'h01;
          state           <= S_EMIT;
        end
        S_EMIT: begin
          if (f_iready) begin
            em_pos <= em_pos + 5'h01;
            em_n   <= em_n - 5'h01;
            if (!is_sp)
              em_val <= em_txt ? {em_val[191:0], 8'h00} : {em_val[195:0], 4'h0};
            if (em_n == 5'h01)
              state <= S_CR;
          end
        end
        S_CR: begin
          if (f_iready)
            state <= S_LF;
        end
        S_LF: begin
          if (f_iready) begin
            if (dmode && dleft != 7'h00) begin
              LOG_RADDR <= didx;
              state     <= S_DRD;
            end else begin
              dmode    <= 1'b0;
              RX_READY <= 1'b1;
              state    <= S_RX;
            end
          end
        end
        default: state <= S_LOAD;
      endcase
    end
  end
endmodule // scp_parser

// *** scp_parser_asserts.sv ***
// port assertions for the serial command parser
// assumes a bind onto scp_parser; counts follow its parameters
`timescale 1ns/100ps
module scp_chk #(
  parameter        CHAR_CYC = 4,
  parameter [41:0] HIST_CYC = 42'd200
) (
  input logic       CLK,
  input logic       SRST,
  input logic [7:0] RX_DATA,
  input logic       RX_VALID,
  input logic       RX_READY,
  input logic       TX_VALID,
  input logic       TX_READY,
  input logic       READY,
  input logic       FLASH_LOAD,
  input logic       FLASH_PARAM_WR,
  input logic       FLASH_HIST_WR,
  input logic       PANEL_TOP,
  input logic       ENABLED,
  input logic       PG_RELOAD,
  input logic       PARAM_WE,
  input logic       ODO_TUBE_CLR,
  input logic       ODO_ANT_CLR
);
  // ----
  // helpers and properties
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [41:0] idle;
  logic [15:0] gap;
  // gap saturates so a long quiet link never wraps into a false alarm
  always @(posedge CLK) begin
    idle <= (SRST || FLASH_HIST_WR) ? 42'h0 : idle + 42'h1;
    gap  <= SRST ? 16'hffff : (TX_VALID && TX_READY) ? 16'h1 : gap + {15'h0, gap != 16'hffff};
  end
  sequence s_one_pulse; FLASH_LOAD ##1 !FLASH_LOAD; endsequence
  property p_boot; $fell(SRST) |=> s_one_pulse; endproperty
  property p_gate; !READY |-> !RX_READY; endproperty
  property p_hold; READY |=> READY; endproperty
  property p_cr; RX_VALID && RX_READY && RX_DATA == 8'h0d |=> !RX_READY; endproperty
  property p_set; PARAM_WE && !PANEL_TOP |-> !FLASH_PARAM_WR [*3]; endproperty
  property p_panel; READY && PANEL_TOP |=> FLASH_PARAM_WR; endproperty
  property p_reload; $rose(ENABLED) |=> PG_RELOAD; endproperty
  property p_drop; READY && $fell(ENABLED) |=> FLASH_HIST_WR; endproperty
  property p_period; idle <= HIST_CYC + 42'h1; endproperty
  property p_both; FLASH_PARAM_WR && !$past(PANEL_TOP) |-> FLASH_HIST_WR; endproperty
  property p_odo; ODO_TUBE_CLR || ODO_ANT_CLR |-> FLASH_HIST_WR; endproperty
  property p_pace; TX_VALID |-> gap >= CHAR_CYC - 1; endproperty
  a_boot: assert property (p_boot) else $error("boot load pulse wrong");
  a_gate: assert property (p_gate) else $error("input open before boot");
  a_hold: assert property (p_hold) else $error("ready dropped");
  a_cr: assert property (p_cr) else $error("input open after cr");
  a_set: assert property (p_set) else $error("set wrote flash");
  a_panel: assert property (p_panel) else $error("panel write missing");
  a_reload: assert property (p_reload) else $error("reload missing");
  a_drop: assert property (p_drop) else $error("history write on drop missing");
  a_period: assert property (p_period) else $error("history interval overrun");
  a_both: assert property (p_both) else $error("copy command wrote one mirror");
  a_odo: assert property (p_odo) else $error("odometer clear without write");
  a_pace: assert property (p_pace) else $error("reply characters too close");
endmodule // scp_chk
bind scp_parser scp_chk #(.CHAR_CYC(CHAR_CYC), .HIST_CYC(HIST_CYC)) u_scp_chk (.*);

// *** scp_host.sv ***
// remote terminal model: feeds queued characters, stalls the reply side
// assumes the clock and synchronous reset of the parser
`timescale 1ns/100ps
module scp_host (
  input  wire logic  CLK,
  input  wire logic  SRST,
  input  wire logic  stall,
  input  wire logic  RX_READY,
  output logic [7:0] RX_DATA,
  output logic       RX_VALID,
  output logic       TX_READY
);
  logic [7:0] rxq[$];
  logic       took;
  initial {RX_VALID, RX_DATA, TX_READY, took} = 0;
  always @(posedge CLK) took = RX_VALID && RX_READY;
  always @(negedge CLK) begin
    if (SRST || took || !RX_VALID) begin
      RX_VALID = !SRST && rxq.size() > 0;
      RX_DATA  = RX_VALID ? rxq.pop_front() : ~RX_DATA;
    end
    TX_READY = !stall && $urandom % 3 != 0;
  end
endmodule // scp_host

// *** tb.sv ***
// self-checking bench for the serial command parser
// assumes the host model carries lines in and paces the reply side
`timescale 1ns/100ps
`include "scp_defines.vh"
module tb;
  logic        CLK, SRST, RX_VALID, RX_READY, TX_VALID, TX_READY, READY, FLASH_LOAD;
  logic        FLASH_DONE, FLASH_PARAM_WR, FLASH_HIST_WR, PANEL_TOP, ENABLED, PG_RELOAD;
  logic        PARAM_WE, PARAM_RE, FACTORY_LOAD, LOG_START, LOG_STOP, FAULT_RESET;
  logic        ODO_TUBE_CLR, ODO_ANT_CLR, stall;
  logic [7:0]  RX_DATA, TX_DATA;
  logic [10:0] PARAM_ADDR;
  logic [11:0] PARAM_WDATA, PARAM_RDATA;
  logic [6:0]  LOG_COUNT;
  logic [5:0]  LOG_RADDR, pv;
  logic [79:0] LOG_RDATA;
  logic [31:0] FAULT_BITS, FIRST_FAULT;
  logic [7:0]  exp[$];
  int          mismatches, checked, pc[6];
  scp_parser #(.CHAR_CYC(4), .HIST_CYC(42'd200)) u_scp_parser (.*);
  scp_host u_scp_host (.*);
  assign pv = {FACTORY_LOAD, FAULT_RESET, LOG_STOP, LOG_START, ODO_ANT_CLR, ODO_TUBE_CLR};
  initial begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  // ----
  // checking
  // ----
  task automatic cmp(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // the parser sends upper-case hex digits
  function automatic string up(input string s);
    return s.toupper();
  endfunction
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a whole line out, its reply noted for the monitor
  task automatic line(input string s, input string r);
    int n;
    for (int i = 0; i < s.len(); i++) u_scp_host.rxq.push_back(s[i]);
    u_scp_host.rxq.push_back(8'h0d);
    u_scp_host.rxq.push_back(8'h0a);
    for (int i = 0; i < r.len(); i++) exp.push_back(r[i]);
    exp.push_back(8'h0d);
    exp.push_back(8'h0a);
    for (n = 0; n < 3000 && exp.size() > 0; n++) @(negedge CLK);
    cmp(n < 3000, 1);
    repeat (4) @(negedge CLK);
  endtask
  always @(posedge CLK) begin
    if (TX_VALID && TX_READY) cmp(TX_DATA, exp.size() > 0 ? exp.pop_front() : 8'hxx);
    if (PARAM_RE) cmp(PARAM_ADDR, 11'h012);
    if (PARAM_WE) cmp({PARAM_ADDR, PARAM_WDATA}, 23'h012abc);
    for (int i = 0; i < 6; i++) pc[i] += pv[i];
  end
  always @(negedge CLK) FLASH_DONE <= FLASH_LOAD;
  initial begin
    repeat (40000) @(posedge CLK);
    mismatches++;
    give_verdict;
  end
  // ----
  // tests
  // ----
  initial begin
    int n;
    string odo[6];
    {SRST, stall, ENABLED, PANEL_TOP} = 4'h8;
    void'($urandom(32'h925379ef));
    {FAULT_BITS, FIRST_FAULT, PARAM_RDATA, LOG_COUNT} = {$urandom, $urandom, $urandom};
    LOG_RDATA = {$urandom, $urandom, $urandom};
    repeat (3) @(negedge CLK);
    SRST = 0;
    for (n = 0; n < 50 && READY !== 1'b1; n++) @(negedge CLK);
    cmp(READY, 1);
    $display("done boot");
    stall = 1;
    fork
      line("?", `SCP_HELP_TEXT);
      begin repeat (150) @(negedge CLK); stall = 0; end
    join
    line("R", "20");
    line("P", "0B");
    line("X", "000100000000");
    $display("done info");
    line("x", up($sformatf("%08x", FAULT_BITS)));
    line("y", up($sformatf("%08x", FIRST_FAULT)));
    line("n", up($sformatf("%02x", LOG_COUNT)));
    line("v12", up($sformatf("%03x", PARAM_RDATA)));
    $display("done reads");
    ENABLED = 1;
    line("V12abc", "");
    line("Wabc", "?");
    line("v12345678", "?");
    ENABLED = 0;
    PANEL_TOP = 1;
    @(negedge CLK) PANEL_TOP = 0;
    $display("done sets");
    odo = '{"Z", "Y", "z", "n", "z", "Y"};
    foreach (odo[i]) line(odo[i], "");
    cmp(pc[0], 1);
    cmp(pc[1], 1);
    $display("done odometers");
    line("S", "");
    line("d", "?");
    line("s", "");
    LOG_COUNT = 7'd2;
    LOG_RDATA = {$urandom, $urandom, $urandom};
    line("d", up($sformatf("000 %012x %08x%c%c001 %012x %08x", LOG_RDATA[79:32],
      LOG_RDATA[31:0], 8'h0d, 8'h0a, LOG_RDATA[79:32], LOG_RDATA[31:0])));
    line("Q", "");
    line("r", "");
    line("F", "");
    cmp({pc[5][7:0], pc[4][7:0], pc[3][7:0], pc[2][7:0]}, 32'h01010101);
    repeat (250) @(negedge CLK);
    $display("done actions");
    give_verdict;
  end
endmodule // tb
